/* File: sim/crystal_osc_model.sv */
/*
 Crystal oscillator model: a 32,768 Hz square wave built from clock.
 Assumes a 250 MHz clock; HALF clocks per half period.
*/
`timescale 1ns/1ps
module crystal_osc_model #(parameter int HALF = 3815) (
   input wire logic clock,
   input wire logic rst,
   output logic crystal_out
);
   int cnt_ff;
   // Runs free like a real crystal; the 3815 rounding is slightly slow
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff <= 0;
         crystal_out <= 1'b0;
      end
      else if (cnt_ff == HALF - 1)
      begin
         cnt_ff <= 0;
         crystal_out <= ~crystal_out;
      end
      else
      begin
         cnt_ff <= cnt_ff + 1;
      end
   end
endmodule

/* File: sim/master_clock_generation_asserts.sv */
/*
 Port checker for the master clock generator.
 Assumes one clock domain and the async high reset rst.
*/
`timescale 1ns/1ps
module master_clock_generation_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic crystal_out,
   input wire logic emulator_enable_pin,
   input wire logic wake_request,
   input wire logic master_clock,
   input wire logic cpu_clock,
   input wire logic cpu_timer_tick,
   input wire logic emulator_clock,
   input wire logic rtc_clock,
   input wire logic sleep_mode,
   input wire logic pll_lock
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // A shortened pulse would end well inside two master periods
   sequence cpu_held_high;
      cpu_clock [*8];
   endsequence
   sequence cpu_held_low;
      !cpu_clock [*8];
   endsequence
   chk_rtc_direct: assert property (rtc_clock == $past(crystal_out))
      else $error("rtc clock not the crystal");
   chk_tick_leads_cpu: assert property (cpu_timer_tick |=> $rose(cpu_clock))
      else $error("timer tick not before cpu rise");
   chk_cpu_high_whole: assert property ($rose(cpu_clock) |-> cpu_held_high)
      else $error("cpu clock high pulse too short");
   chk_cpu_low_whole: assert property ($fell(cpu_clock) |-> cpu_held_low)
      else $error("cpu clock low pulse too short");
   chk_sleep_still: assert property (sleep_mode && !master_clock |=> !master_clock)
      else $error("master clock runs in sleep");
   chk_sleep_unlocked: assert property (sleep_mode |-> !pll_lock)
      else $error("lock shown while loop off");
   chk_wake_unlocked: assert property ($fell(sleep_mode) |-> !pll_lock [*8])
      else $error("lock shown at once after wake");
   chk_wake_prompt: assert property (sleep_mode && wake_request |-> ##[1:2] !sleep_mode)
      else $error("wake request ignored");
   chk_emu_parked: assert property (!emulator_enable_pin [*3] |=> !$rose(emulator_clock))
      else $error("emulator clock runs with pin low");
endmodule
bind master_clock_generation master_clock_generation_asserts u_chk (.clock, .rst,
   .crystal_out, .emulator_enable_pin, .wake_request, .master_clock, .cpu_clock,
   .cpu_timer_tick, .emulator_clock, .rtc_clock, .sleep_mode, .pll_lock);

/* File: sim/master_clock_generation_tb.sv */
/*
 Testbench for the master clock generator: AHB-Lite tasks and scenarios.
 Assumes the crystal model at true rate and hreadyout fed back as hready.
*/
`timescale 1ns/1ps
module master_clock_generation_tb import clock_gen_pkg::*;;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic emulator_enable_pin = 1'b0;
   logic wake_request = 1'b0;
   logic hreadyout, hresp, crystal_out, master_clock, cpu_clock, cpu_timer_tick;
   logic emulator_clock, rtc_clock, sleep_mode, pll_lock, irq;
   logic [31:0] hrdata, rd;
   int bad_count = 0;
   int n_compared = 0;
   int n, d, k;
   always #2 clock = ~clock;
   crystal_osc_model xtal (.clock, .rst, .crystal_out);
   master_clock_generation dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .crystal_out,
      .emulator_enable_pin, .wake_request, .master_clock, .cpu_clock, .cpu_timer_tick,
      .emulator_clock, .rtc_clock, .sleep_mode, .pll_lock, .irq);
   task automatic final_report;
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask
   // Master rises between two rises of the cpu or emulator clock
   task automatic ratio(input logic emu, output int cnt);
      logic pm, ps, s;
      bit on;
      cnt = 0;
      on = 0;
      pm = master_clock;
      ps = emu ? emulator_clock : cpu_clock;
      repeat (6000)
      begin
         @(negedge clock);
         s = emu ? emulator_clock : cpu_clock;
         if (on && master_clock && !pm) cnt++;
         pm = master_clock;
         if (s && !ps && on) break;
         if (s && !ps) on = 1;
         ps = s;
      end
      @(posedge clock);
   endtask
   initial
   begin
      repeat (110000) @(posedge clock);
      bad_count++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report;
   end
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rchk(OFS_CTRL, 32'h1F, 32'h0);
      rchk(OFS_STATUS, 32'h7F, 32'h2);
      rchk(OFS_INT_MASK, 32'hF, 32'h0);
      rchk(8'h14, 32'hFFFFFFFF, 32'h0);
      check(hresp, 32'h0);
      for (k = 0; k < 70000 && pll_lock !== 1'b1; k++) @(posedge clock);
      check(pll_lock, 32'h1);
      bus(1'b0, OFS_MEASURE, 32'h0);
      check(32'(rd[9:0] >= 10'd191 && rd[9:0] <= 10'd193), 32'h1);
      rchk(OFS_INT_STATUS, 32'h1, 32'h1);
      check(irq, 32'h0);
      bus(1'b1, OFS_INT_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 32'h1);
      bus(1'b1, OFS_INT_STATUS, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 32'h0);
      for (d = 0; d <= 4; d++)
      begin
         bus(1'b1, OFS_CTRL, 32'(d << 1));
         for (k = 0; k < 3000 && rd[6:4] !== 3'(d); k++) bus(1'b0, OFS_STATUS, 32'h0);
         ratio(1'b0, n);
         check(n, 32'(1 << (d + 2)));
      end
      bus(1'b1, OFS_CTRL, 32'hA);
      rchk(OFS_CTRL, 32'hE, 32'h8);
      emulator_enable_pin <= 1'b1;
      ratio(1'b1, n);
      check(n, 32'h2);
      rchk(OFS_STATUS, 32'h8, 32'h8);
      emulator_enable_pin <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (24000) @(posedge clock);
      bus(1'b0, OFS_MEASURE, 32'h0);
      check(32'(rd[9:0] >= 10'd598 && rd[9:0] <= 10'd602), 32'h1);
      rchk(OFS_INT_STATUS, 32'h2, 32'h2);
      bus(1'b1, OFS_CTRL, 32'h11);
      repeat (200) @(posedge clock);
      check(sleep_mode, 32'h1);
      check(master_clock, 32'h0);
      rchk(OFS_STATUS, 32'h7, 32'h4);
      rchk(OFS_INT_STATUS, 32'h8, 32'h8);
      wake_request <= 1'b1;
      repeat (4) @(posedge clock);
      wake_request <= 1'b0;
      repeat (2) @(posedge clock);
      check(sleep_mode, 32'h0);
      check(pll_lock, 32'h0);
      rchk(OFS_CTRL, 32'h1, 32'h0);
      rchk(OFS_STATUS, 32'h3, 32'h2);
      rchk(OFS_INT_STATUS, 32'h4, 32'h4);
      // Before lock the divider moves to 2; speed bit is written 0 and stays clear
      bus(1'b1, OFS_CTRL, 32'h4);
      rchk(OFS_CTRL, 32'hF, 32'h4);
      final_report;
   end
endmodule

/* File: src/clock_gen_pkg.sv */
/*
 Constants for the master clock generator: bus map, field positions,
 reset values and the rate figures of the frequency-locked loop.
 Assumes a 250 MHz system clock and a 32,768 Hz crystal level input.
*/
package clock_gen_pkg;
   // Rates
   localparam longint CLOCK_HZ = 250000000;
   localparam longint XTAL_HZ = 32768;
   localparam longint MASTER_FAST_HZ = 19660800;
   localparam logic [9:0] MULT_FAST = 10'd600;
   localparam logic [9:0] MULT_SLOW = 10'd192;
   // Accumulator step for one master toggle pair at each rate
   localparam logic [31:0] INC_FAST =
      32'((64'd2 * MASTER_FAST_HZ * (64'd1 << 32)) / CLOCK_HZ);
   localparam logic [31:0] INC_SLOW =
      32'((64'd2 * MASTER_FAST_HZ * 64'd192 * (64'd1 << 32)) / (CLOCK_HZ * 64'd600));
   // Restart well below target so lock has to be earned
   localparam logic [31:0] INC_START = 32'(INC_SLOW >> 1);
   localparam logic [32:0] INC_PER_COUNT =
      33'((64'd2 * XTAL_HZ * (64'd1 << 32)) / CLOCK_HZ);
   localparam logic [2:0] LOCK_PERIODS = 3'd4;
   localparam logic [2:0] DIV_MAX = 3'd4;
   localparam logic [2:0] DIV_RESET = 3'd0;
   localparam logic SPEED_RESET = 1'b0;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STATUS = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;
   localparam logic [7:0] OFS_MEASURE = 8'h10;

   // CTRL fields
   localparam int CTRL_SPEED = 0;
   localparam int CTRL_DIV_LO = 1;
   localparam int CTRL_SLEEP = 4;
   // STATUS fields
   localparam int ST_LOCK = 0;
   localparam int ST_PLL_ON = 1;
   localparam int ST_SLEEP = 2;
   localparam int ST_EMU = 3;
   localparam int ST_DIV_LO = 4;
   // Interrupt events
   localparam int EV_LOCK_GAIN = 0;
   localparam int EV_LOCK_LOSS = 1;
   localparam int EV_WAKE = 2;
   localparam int EV_SLEEP = 3;
   localparam int EV_COUNT = 4;
   localparam logic [3:0] MASK_RESET = 4'h0;

   typedef enum logic [1:0]
   {
      PLL_OFF = 2'b00,
      PLL_ACQUIRE = 2'b01,
      PLL_LOCKED = 2'b11
   } pll_state_t;
endpackage

/* File: src/cpu_clock_divider_gen.sv */
/*
 Processor clock divider: divides the master clock by 2^(n+2).
 Assumes master_rise is a one-cycle pulse per master clock rising edge.
*/
`timescale 1ns/1ps
module cpu_clock_divider_gen import clock_gen_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic master_rise,
   input wire logic [2:0] divider,
   output logic cpu_clock,
   output logic cpu_tick,
   output logic [2:0] active_div
);
   logic cpu_ff;
   logic [2:0] div_ff;
   logic [5:0] cnt_ff;
   logic hit;

   function automatic logic [5:0] half_last(input logic [2:0] d);
      half_last = 6'((7'd1 << (d + 3'd1)) - 7'd1);
   endfunction

   assign hit = master_rise && (cnt_ff == half_last(div_ff));

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cnt_ff <= 6'h00;
      else if (hit)
         cnt_ff <= 6'h00;
      else if (master_rise)
         cnt_ff <= 6'(cnt_ff + 6'h01);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cpu_ff <= 1'b0;
      else if (hit)
         cpu_ff <= ~cpu_ff;
   end

   // New ratio only at the falling edge, so no short pulse escapes
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         div_ff <= DIV_RESET;
      else if (hit && cpu_ff)
         div_ff <= divider;
   end

   assign cpu_clock = cpu_ff;
   assign cpu_tick = hit && !cpu_ff;
   assign active_div = div_ff;
endmodule

/* File: src/master_clock_generation.sv */
/*
 Master clock generation: a frequency-locked loop referenced to the
 crystal, processor clock divider, emulator clock, sleep and wake
 control, with an AHB-Lite register slave and one interrupt.
 Assumes all pins are synchronous to clock; single-slave AHB-Lite bus.
*/
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module master_clock_generation import clock_gen_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic crystal_out,
   input wire logic emulator_enable_pin,
   input wire logic wake_request,
   output logic master_clock,
   output logic cpu_clock,
   output logic cpu_timer_tick,
   output logic emulator_clock,
   output logic rtc_clock,
   output logic sleep_mode,
   output logic pll_lock,
   output logic irq
);
   pll_state_t state_ff, nxt_state;
   logic xtal_d_ff;
   logic rtc_ff;
   logic [31:0] acc_ff;
   logic [31:0] inc_ff, nxt_inc;
   logic master_ff;
   logic emu_ff;
   logic [9:0] cnt_ff;
   logic [9:0] meas_ff;
   logic meas_valid_ff;
   logic [2:0] good_ff;
   logic speed_ff;
   logic [2:0] div_ff;
   logic [EV_COUNT-1:0] int_status_ff;
   logic [EV_COUNT-1:0] int_mask_ff;
   logic [EV_COUNT-1:0] events;
   logic wr_pend_ff;
   logic [7:0] waddr_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rd_mux;
   logic xtal_rise;
   logic [32:0] acc_sum;
   logic pll_run;
   logic tick;
   logic master_rise;
   logic [9:0] target;
   logic signed [10:0] err;
   logic close;
   logic locked_now;
   logic addr_phase;
   logic ctrl_wr;
   logic sleep_go;
   logic wake_go;
   logic [2:0] active_div;
   logic [2:0] wr_div;

   // Crystal edge and RTC clock
   assign xtal_rise = crystal_out && !xtal_d_ff;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         xtal_d_ff <= 1'b0;
      else
         xtal_d_ff <= crystal_out;
   end

   // RTC bypasses the loop entirely
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rtc_ff <= 1'b0;
      else
         rtc_ff <= crystal_out;
   end

   // Loop state
   assign pll_run = (state_ff != PLL_OFF);
   assign locked_now = (good_ff == LOCK_PERIODS);

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         PLL_OFF:
         begin
            if (wake_go)
               nxt_state = PLL_ACQUIRE;
         end
         PLL_ACQUIRE:
         begin
            if (sleep_go)
               nxt_state = PLL_OFF;
            else if (locked_now)
               nxt_state = PLL_LOCKED;
         end
         PLL_LOCKED:
         begin
            if (sleep_go)
               nxt_state = PLL_OFF;
            else if (!locked_now)
               nxt_state = PLL_ACQUIRE;
         end
         default:
            nxt_state = PLL_ACQUIRE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state_ff <= PLL_ACQUIRE;
      else
         state_ff <= nxt_state;
   end

   assign wake_go = (state_ff == PLL_OFF) && wake_request;

   // Oscillator: accumulator carry toggles the master clock
   assign acc_sum = {1'b0, acc_ff} + {1'b0, inc_ff};
   // Finishes a high phase on sleep so master always parks low
   assign tick = acc_sum[32] && (pll_run || master_ff);
   assign master_rise = tick && !master_ff;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         acc_ff <= 32'h00000000;
      else if (pll_run || master_ff)
         acc_ff <= acc_sum[31:0];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         master_ff <= 1'b0;
      else if (tick)
         master_ff <= ~master_ff;
   end

   // Master edges counted over each crystal period
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         cnt_ff <= 10'h000;
      else if (xtal_rise || !pll_run)
         cnt_ff <= {9'h000, master_rise};
      else if (master_rise && cnt_ff != 10'h3FF)
         cnt_ff <= 10'(cnt_ff + 10'h001);
   end

   // First period after start is partial and is thrown away
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         meas_valid_ff <= 1'b0;
      else if (!pll_run)
         meas_valid_ff <= 1'b0;
      else if (xtal_rise)
         meas_valid_ff <= 1'b1;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         meas_ff <= 10'h000;
      else if (xtal_rise && meas_valid_ff)
         meas_ff <= cnt_ff;
   end

   assign target = speed_ff ? MULT_FAST : MULT_SLOW;
   assign err = $signed({1'b0, target}) - $signed({1'b0, cnt_ff});
   assign close = (err >= -11'sd1) && (err <= 11'sd1);

   // Frequency step: one count of error is one master edge per period
   always_comb
   begin
      nxt_inc = inc_ff;
      if (sleep_go || wake_go)
         nxt_inc = INC_START;
      else if (pll_run && xtal_rise && meas_valid_ff)
         nxt_inc = inc_ff + 32'($signed(err) * $signed(INC_PER_COUNT));
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         inc_ff <= INC_START;
      else
         inc_ff <= nxt_inc;
   end

   // Lock only after several accurate periods in a row
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         good_ff <= 3'd0;
      else if (!pll_run)
         good_ff <= 3'd0;
      else if (xtal_rise && meas_valid_ff)
      begin
         if (!close)
            good_ff <= 3'd0;
         else if (!locked_now)
            good_ff <= 3'(good_ff + 3'd1);
      end
   end

   // Processor clock and timer tick
   cpu_clock_divider_gen u_cpu_div (
      .clock(clock),
      .rst(rst),
      .master_rise(master_rise),
      .divider(div_ff),
      .cpu_clock(cpu_clock),
      .cpu_tick(cpu_timer_tick),
      .active_div(active_div)
   );

   // Emulator clock: master halved, parks low when pin drops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         emu_ff <= 1'b0;
      else if (master_rise)
         emu_ff <= emulator_enable_pin && !emu_ff;
   end

   // Bus slave, zero wait states
   assign addr_phase = hsel && htrans[1] && hready;
   assign ctrl_wr = wr_pend_ff && (waddr_ff == OFS_CTRL);
   assign sleep_go = ctrl_wr && hwdata[CTRL_SLEEP] && pll_run;
   assign wr_div = hwdata[CTRL_DIV_LO +: 3];

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wr_pend_ff <= 1'b0;
      else if (hready)
         wr_pend_ff <= addr_phase && hwrite;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         waddr_ff <= 8'h00;
      else if (addr_phase)
         waddr_ff <= {haddr[7:2], 2'b00};
   end

   // Speed is forced slow on sleep so wake restarts there
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         speed_ff <= SPEED_RESET;
      else if (sleep_go)
         speed_ff <= 1'b0;
      else if (ctrl_wr)
         speed_ff <= hwdata[CTRL_SPEED];
   end

   // Out-of-range divider values keep the old setting
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         div_ff <= DIV_RESET;
      else if (ctrl_wr && wr_div <= DIV_MAX)
         div_ff <= wr_div;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         int_mask_ff <= MASK_RESET;
      else if (wr_pend_ff && waddr_ff == OFS_INT_MASK)
         int_mask_ff <= hwdata[EV_COUNT-1:0];
   end

   assign events[EV_LOCK_GAIN] = (state_ff == PLL_ACQUIRE) && (nxt_state == PLL_LOCKED);
   assign events[EV_LOCK_LOSS] = (state_ff == PLL_LOCKED) && (nxt_state == PLL_ACQUIRE);
   assign events[EV_WAKE] = wake_go;
   assign events[EV_SLEEP] = sleep_go;

   // Write one clears; a new event in the same cycle wins
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         int_status_ff <= '0;
      else if (wr_pend_ff && waddr_ff == OFS_INT_STATUS)
         int_status_ff <= (int_status_ff & ~hwdata[EV_COUNT-1:0]) | events;
      else
         int_status_ff <= int_status_ff | events;
   end

   always_comb
   begin
      rd_mux = 32'h00000000;
      case ({haddr[7:2], 2'b00})
         OFS_CTRL:
         begin
            rd_mux[CTRL_SPEED] = speed_ff;
            rd_mux[CTRL_DIV_LO +: 3] = div_ff;
         end
         OFS_STATUS:
         begin
            rd_mux[ST_LOCK] = (state_ff == PLL_LOCKED);
            rd_mux[ST_PLL_ON] = pll_run;
            rd_mux[ST_SLEEP] = !pll_run;
            rd_mux[ST_EMU] = emulator_enable_pin;
            rd_mux[ST_DIV_LO +: 3] = active_div;
         end
         OFS_INT_STATUS:
            rd_mux[EV_COUNT-1:0] = int_status_ff;
         OFS_INT_MASK:
            rd_mux[EV_COUNT-1:0] = int_mask_ff;
         OFS_MEASURE:
            rd_mux[9:0] = meas_ff;
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata_ff <= 32'h00000000;
      else if (addr_phase && !hwrite)
         rdata_ff <= rd_mux;
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign master_clock = master_ff;
   assign emulator_clock = emu_ff;
   assign rtc_clock = rtc_ff;
   assign sleep_mode = !pll_run;
   assign pll_lock = (state_ff == PLL_LOCKED);
   assign irq = |(int_status_ff & int_mask_ff);
endmodule
